// *** hdl/swc_pkg.sv ***
/*
  Shared constants, types and helpers for the serial word check block.
  Assumes a single 25 MHz clock and a simple strobe register port.
*/
package swc_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS = 40;
  localparam int BIT_NS = 10000;
  localparam int HALF_BIT_CYC = BIT_NS / 2 / CLK_NS;
  localparam int GAP_BITS = 4;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_REC_DATA = 8'h0c;
  localparam logic [7:0] REG_REC_CMD = 8'h10;
  localparam logic [7:0] REG_CKSUM = 8'h14;
  localparam logic [1:0] SLOT_REGION = 2'h1;
  localparam logic [1:0] SLOT_WORD = 2'h0;
  localparam logic [1:0] SLOT_MIN = 2'h1;
  localparam logic [1:0] SLOT_MAX = 2'h2;
  localparam logic [1:0] SLOT_FLAGS = 2'h3;
  localparam int CTRL_EN = 0;
  localparam int CTRL_HEAVY = 1;
  localparam int FLAG_EN = 0;
  localparam int FLAG_HOLD = 1;
  localparam int FLAG_FRESH = 2;

  // ----------------------------------------
  // Record commands and word fields
  // ----------------------------------------
  localparam logic [1:0] REC_INIT = 2'h1;
  localparam logic [1:0] REC_MID = 2'h2;
  localparam logic [1:0] REC_CLOSE = 2'h3;
  // Final word code value is arbitrary
  localparam logic [1:0] FINAL_CODE = 2'h2;
  localparam int CKS_W = 21;
  localparam int CKS_LSB = 8;
  localparam int SDF_LSB = 8;

  // ----------------------------------------
  // Status bits
  // ----------------------------------------
  localparam int ST_SENT = 0;
  localparam int ST_CLOSED = 1;
  localparam int ST_OVERDUE = 2;
  localparam int ST_STALE = 3;
  localparam int ST_RECERR = 4;
  localparam int NST = 5;

  typedef enum logic [2:0] {
    SER_IDLE = 3'b001,
    SER_BIT = 3'b010,
    SER_GAP = 3'b100
  } swc_ser_t;

  // Bit that makes the 32-bit word hold an odd count of ones
  function automatic logic swc_odd_par(input logic [30:0] w);
    return ~^w;
  endfunction
endpackage

// *** hdl/swc_serializer.sv ***
/*
  Return-to-zero serialiser for 32-bit words, bit 0 first.
  Assumes the word already carries its parity bit.
*/
`timescale 1ns/1ps
`default_nettype none
module swc_serializer import swc_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  swc_tx_if.ser tx,
  output logic hi_q,
  output logic lo_q
);
  swc_ser_t state_q;
  logic [31:0] sh_q;
  logic [5:0] cnt_q;
  logic ph_q;
  logic [7:0] div_q;
  logic done_q;
  logic half_en;

  assign half_en = (div_q == 8'(HALF_BIT_CYC - 1)) && state_q != SER_IDLE;
  assign tx.ready = state_q == SER_IDLE;
  assign tx.done = done_q;

  always_ff @(posedge clk) begin
    if (rst || state_q == SER_IDLE || half_en) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // ----------------------------------------
  // Bit sequencing
  // ----------------------------------------
  always_ff @(posedge clk) begin
    done_q <= 1'b0;
    if (rst) begin
      state_q <= SER_IDLE;
      sh_q <= '0;
      cnt_q <= '0;
      ph_q <= 1'b0;
      hi_q <= 1'b0;
      lo_q <= 1'b0;
    end else begin
      case (state_q)
        SER_IDLE: begin
          if (tx.valid) begin
            sh_q <= tx.word;
            cnt_q <= '0;
            ph_q <= 1'b0;
            hi_q <= tx.word[0];
            lo_q <= ~tx.word[0];
            state_q <= SER_BIT;
          end
        end
        SER_BIT: begin
          if (half_en && !ph_q) begin
            ph_q <= 1'b1;
            hi_q <= 1'b0;
            lo_q <= 1'b0;
          end else if (half_en) begin
            ph_q <= 1'b0;
            if (cnt_q == 6'h1f) begin
              cnt_q <= '0;
              state_q <= SER_GAP;
            end else begin
              cnt_q <= cnt_q + 6'h01;
              sh_q <= sh_q >> 1;
              hi_q <= sh_q[1];
              lo_q <= ~sh_q[1];
            end
          end
        end
        SER_GAP: begin
          // Null gap keeps word boundaries visible to receivers
          if (half_en && cnt_q == 6'(2 * GAP_BITS - 1)) begin
            state_q <= SER_IDLE;
            done_q <= 1'b1;
          end else if (half_en) begin
            cnt_q <= cnt_q + 6'h01;
          end
        end
        default: state_q <= SER_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** hdl/swc_tx_if.sv ***
/*
  Word hand-off between the scheduler and the serialiser.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface swc_tx_if;
  logic [31:0] word;
  logic valid;
  logic ready;
  logic done;
  modport src (output word, output valid, input ready, input done);
  modport ser (input word, input valid, output ready, output done);
endinterface
`default_nettype wire

// *** hdl/swc_word_tx.sv ***
/*
  Word transmitter with odd parity, record closing checksum and
  per-slot interval scheduling. Assumes a same-clock register master.
*/
`timescale 1ns/1ps
`default_nettype none
module swc_word_tx import swc_pkg::*; #(
  parameter int SLOTS = 4,
  parameter int IW = 16,
  parameter int TICK = TICK_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata_q,
  output logic irq_q,
  output logic line_hi_q,
  output logic line_lo_q
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  // Slot index is two bits wide: at most four slots
  logic [1:0] ctrl_q;
  logic [NST-1:0] stat_q, mask_q, ev;
  logic [30:0] rec_data_q;
  logic [31:0] rec_word_q, tword_q;
  logic [CKS_W-1:0] cks_q;
  logic rec_open_q, rec_pend_q, tvld_q;
  logic [30:0] sw_q [SLOTS];
  logic [IW-1:0] smin_q [SLOTS];
  logic [IW-1:0] smax_q [SLOTS];
  logic [IW-1:0] scnt_q [SLOTS];
  logic [SLOTS-1:0] sen_q, shold_q, sfresh_q, due, ovd;
  logic [31:0] tdiv_q;
  logic tick_q, any_due, load, slot_go, rec_go;
  logic [1:0] sel;
  logic cmd_wr, cmd_init_ok, cmd_mid_ok, cmd_close_ok;
  logic [IW-1:0] sel_cnt, sel_min, sel_max;
  logic s_hi, s_lo;
  swc_tx_if txi ();
  function automatic logic is_slot(input logic [7:0] a, input int n);
    return a[7:6] == SLOT_REGION && int'(a[5:4]) < n;
  endfunction

  // ----------------------------------------
  // Control, mask, interval tick
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= '0;
      mask_q <= '0;
    end else if (wr && addr == REG_CTRL) begin
      ctrl_q <= wdata[1:0];
    end else if (wr && addr == REG_MASK) begin
      mask_q <= wdata[NST-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst || tdiv_q == 32'(TICK - 1)) begin
      tdiv_q <= '0;
    end else begin
      tdiv_q <= tdiv_q + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    tick_q <= !rst && tdiv_q == 32'(TICK - 1);
  end

  // ----------------------------------------
  // Record framing and checksum
  // ----------------------------------------
  // A command while the previous word still waits is refused
  assign cmd_wr = wr && addr == REG_REC_CMD && !rec_pend_q;
  assign cmd_init_ok = cmd_wr && wdata[1:0] == REC_INIT;
  assign cmd_mid_ok = cmd_wr && wdata[1:0] == REC_MID && rec_open_q;
  assign cmd_close_ok = cmd_wr && wdata[1:0] == REC_CLOSE && rec_open_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      rec_data_q <= '0;
    end else if (wr && addr == REG_REC_DATA) begin
      rec_data_q <= wdata[30:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rec_open_q <= 1'b0;
      cks_q <= '0;
      rec_word_q <= '0;
      rec_pend_q <= 1'b0;
    end else begin
      if (rec_go) begin
        rec_pend_q <= 1'b0;
      end
      if (cmd_init_ok) begin
        rec_open_q <= 1'b1;
        cks_q <= '0;
        rec_word_q <= {swc_odd_par(rec_data_q), rec_data_q};
        rec_pend_q <= 1'b1;
      end else if (cmd_mid_ok) begin
        // Bits above the 21 kept would only be truncated away
        cks_q <= cks_q + rec_data_q[CKS_LSB +: CKS_W];
        rec_word_q <= {swc_odd_par(rec_data_q), rec_data_q};
        rec_pend_q <= 1'b1;
      end else if (cmd_close_ok) begin
        rec_open_q <= 1'b0;
        rec_word_q <= {swc_odd_par({FINAL_CODE, cks_q, rec_data_q[7:0]}),
                       FINAL_CODE, cks_q, rec_data_q[7:0]};
        rec_pend_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Periodic slots
  // ----------------------------------------
  for (genvar i = 0; i < SLOTS; i++) begin : g_slot
    logic [IW:0] mid;
    logic hit;
    assign hit = wr && is_slot(addr, SLOTS) && int'(addr[5:4]) == i;
    assign mid = ({1'b0, smin_q[i]} + {1'b0, smax_q[i]}) >> 1;
    // Normal load aims mid-range, heavy load waits for the maximum
    assign due[i] = sen_q[i] && scnt_q[i] >= smin_q[i] &&
      (ctrl_q[CTRL_HEAVY] ? scnt_q[i] >= smax_q[i]
                          : {1'b0, scnt_q[i]} >= mid);
    assign ovd[i] = sen_q[i] && scnt_q[i] > smax_q[i];

    always_ff @(posedge clk) begin
      if (rst) begin
        sw_q[i] <= '0;
        smin_q[i] <= '0;
        smax_q[i] <= '0;
        sen_q[i] <= 1'b0;
        shold_q[i] <= 1'b0;
      end else if (hit && addr[3:2] == SLOT_WORD) begin
        sw_q[i] <= wdata[30:0];
      end else if (hit && addr[3:2] == SLOT_MIN) begin
        smin_q[i] <= wdata[IW-1:0];
      end else if (hit && addr[3:2] == SLOT_MAX) begin
        smax_q[i] <= wdata[IW-1:0];
      end else if (hit && addr[3:2] == SLOT_FLAGS) begin
        sen_q[i] <= wdata[FLAG_EN];
        shold_q[i] <= wdata[FLAG_HOLD];
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        sfresh_q[i] <= 1'b0;
      end else if (hit && addr[3:2] == SLOT_WORD) begin
        sfresh_q[i] <= 1'b1;
      end else if (slot_go && sel == 2'(i)) begin
        sfresh_q[i] <= 1'b0;
      end
    end

    always_ff @(posedge clk) begin
      if (rst || (slot_go && sel == 2'(i))) begin
        scnt_q[i] <= '0;
      end else if (tick_q && scnt_q[i] != '1) begin
        scnt_q[i] <= scnt_q[i] + 1'b1;
      end
    end
  end

  always_comb begin
    any_due = 1'b0;
    sel = '0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (due[i]) begin
        any_due = 1'b1;
        sel = 2'(i);
      end
    end
  end
  assign sel_cnt = scnt_q[sel];
  assign sel_min = smin_q[sel];
  assign sel_max = smax_q[sel];

  // ----------------------------------------
  // Word hand-off, record words first
  // ----------------------------------------
  assign load = !tvld_q && txi.ready;
  assign rec_go = load && rec_pend_q;
  assign slot_go = load && !rec_pend_q && ctrl_q[CTRL_EN] && any_due;

  // Detection only: a failed word is never resent here
  always_ff @(posedge clk) begin
    if (rst) begin
      tvld_q <= 1'b0;
      tword_q <= '0;
    end else if (tvld_q && txi.ready) begin
      tvld_q <= 1'b0;
    end else if (rec_go) begin
      tvld_q <= 1'b1;
      tword_q <= rec_word_q;
    end else if (slot_go) begin
      tvld_q <= 1'b1;
      tword_q <= {swc_odd_par(sw_q[sel]), sw_q[sel]};
    end
  end

  assign txi.word = tword_q;
  assign txi.valid = tvld_q;

  swc_serializer u_ser (
    .clk(clk),
    .rst(rst),
    .tx(txi),
    .hi_q(s_hi),
    .lo_q(s_lo)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      line_hi_q <= 1'b0;
      line_lo_q <= 1'b0;
    end else begin
      line_hi_q <= s_hi;
      line_lo_q <= s_lo;
    end
  end

  // ----------------------------------------
  // Status, interrupt, read port
  // ----------------------------------------
  always_comb begin
    ev = '0;
    ev[ST_SENT] = txi.done;
    ev[ST_CLOSED] = cmd_close_ok;
    ev[ST_OVERDUE] = |ovd;
    ev[ST_STALE] = slot_go && !sfresh_q[sel] && !shold_q[sel];
    ev[ST_RECERR] = wr && addr == REG_REC_CMD &&
      !(cmd_init_ok || cmd_mid_ok || cmd_close_ok);
  end

  // Set wins over a same-cycle write-one clear
  always_ff @(posedge clk) begin
    if (rst) begin
      stat_q <= '0;
    end else if (wr && addr == REG_STATUS) begin
      stat_q <= (stat_q & ~wdata[NST-1:0]) | ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end

  always_ff @(posedge clk) begin
    irq_q <= !rst && |(stat_q & mask_q);
  end

  always_ff @(posedge clk) begin
    rdata_q <= '0;
    if (!rst && rd) begin
      if (addr == REG_CTRL) begin
        rdata_q <= {29'h0, rec_open_q, ctrl_q};
      end else if (addr == REG_STATUS) begin
        rdata_q <= 32'(stat_q);
      end else if (addr == REG_MASK) begin
        rdata_q <= 32'(mask_q);
      end else if (addr == REG_REC_DATA) begin
        rdata_q <= {1'b0, rec_data_q};
      end else if (addr == REG_CKSUM) begin
        rdata_q <= 32'(cks_q);
      end else if (is_slot(addr, SLOTS)) begin
        case (addr[3:2])
          SLOT_WORD: rdata_q <= {1'b0, sw_q[addr[5:4]]};
          SLOT_MIN: rdata_q <= 32'(smin_q[addr[5:4]]);
          SLOT_MAX: rdata_q <= 32'(scnt_q[addr[5:4]]);
          default: rdata_q <= {29'h0, sfresh_q[addr[5:4]],
            shold_q[addr[5:4]], sen_q[addr[5:4]]};
        endcase
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_word_odd;
    tvld_q |-> (^tword_q) ##1 (!tvld_q || $stable(tword_q));
  endproperty
  a_word_odd: assert property (p_word_odd)
    else $error("word handed on with even parity");
  property p_final_label;
    cmd_close_ok |=> rec_word_q[7:0] == $past(rec_data_q[7:0]);
  endproperty
  a_final_label: assert property (p_final_label)
    else $error("final word label wrong");
  property p_final_cks;
    cmd_close_ok |=> rec_word_q[CKS_LSB +: CKS_W] == $past(cks_q);
  endproperty
  a_final_cks: assert property (p_final_cks)
    else $error("final word checksum wrong");
  property p_final_code;
    cmd_close_ok |=> rec_word_q[30:29] == FINAL_CODE && !rec_open_q;
  endproperty
  a_final_code: assert property (p_final_code)
    else $error("final word code wrong");
  property p_final_par;
    cmd_close_ok |=> ^rec_word_q ##1 (rec_pend_q || tvld_q);
  endproperty
  a_final_par: assert property (p_final_par)
    else $error("final word parity not odd");
  property p_cks_clear;
    cmd_init_ok |=> cks_q == '0 && rec_open_q;
  endproperty
  a_cks_clear: assert property (p_cks_clear)
    else $error("checksum not cleared at record start");
  property p_cks_add;
    cmd_mid_ok |=>
      cks_q == CKS_W'($past(cks_q) + $past(rec_data_q[28:8]));
  endproperty
  a_cks_add: assert property (p_cks_add)
    else $error("checksum sum wrong");
  property p_min_gap;
    slot_go |-> sel_cnt >= sel_min;
  endproperty
  a_min_gap: assert property (p_min_gap)
    else $error("slot sent before its minimum interval");
  property p_heavy;
    slot_go && ctrl_q[CTRL_HEAVY] |-> sel_cnt >= sel_max;
  endproperty
  a_heavy: assert property (p_heavy)
    else $error("heavy load send before maximum interval");
  property p_stale;
    slot_go && !sfresh_q[sel] && !shold_q[sel] |=> stat_q[ST_STALE];
  endproperty
  a_stale: assert property (p_stale)
    else $error("unrefreshed send not flagged");
  property p_repeat;
    slot_go |=> scnt_q[$past(sel)] == '0 ##1 tvld_q == 1'b0;
  endproperty
  a_repeat: assert property (p_repeat)
    else $error("slot interval not restarted on send");
  c_close: cover property (cmd_close_ok ##1 rec_go);
  c_heavy: cover property (slot_go && ctrl_q[CTRL_HEAVY]);
  c_stale: cover property (ev[ST_STALE] ##[1:3] irq_q);
  c_sent: cover property (txi.done);
endmodule
`default_nettype wire

// *** verification/serial_word_check_and_record_close_test.sv ***
/*
  Self-checking bench for swc_word_tx: registers, records, parity,
  slot pacing, interrupt and mid-run reset.
  Assumes swc_pkg, swc_word_tx and swc_rx_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module serial_word_check_and_record_close_test import swc_pkg::*;;
  localparam int TK = 10;
  localparam int MN = 950;
  localparam int MX = 1000;
  logic clk, rst, wr, rd, irq_q, line_hi_q, line_lo_q;
  logic rx_got, rx_perr, rx_bad;
  logic [7:0] addr;
  logic [31:0] wdata, rdata_q, rx_word, rx_start, t0, dl;
  logic [71:0] rows [7];
  int failures = 0;
  int compares = 0;

  swc_word_tx #(.TICK(TK)) swc_word_tx_inst (.clk(clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
    .irq_q(irq_q), .line_hi_q(line_hi_q), .line_lo_q(line_lo_q));
  swc_rx_model swc_rx_model_inst (.clk(clk), .rst(rst), .hi(line_hi_q),
    .lo(line_lo_q), .word_q(rx_word), .got_q(rx_got),
    .par_err_q(rx_perr), .bad_q(rx_bad), .start_q(rx_start));

  // ----------------------------------------
  // Bus and line helpers
  // ----------------------------------------
  task conclude();
    if (failures == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(rdata_q, e)
  endtask
  function automatic logic [31:0] par(input logic [30:0] w);
    return {~^w, w};
  endfunction
  // Word plus 8 half-bit gap can take over 9000 cycles
  task get_word(input logic [31:0] e);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (rx_got !== 1'b1 && n < 12000);
    if (n >= 12000) begin
      failures++;
      conclude();
    end else begin
      `CHK(rx_word, e)
      `CHK(rx_perr, 1'b0)
    end
  endtask

  // ----------------------------------------
  // Clock, watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    conclude();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst, wr, rd, addr, wdata} <= {1'b1, 42'h0};
    rows[0] = {REG_MASK, 32'h1f, 32'h1f};
    rows[1] = {REG_MASK, 32'h0, 32'h0};
    rows[2] = {8'h44, 32'h3b6, 32'h3b6};
    rows[3] = {8'h54, 32'hffff, 32'hffff};
    rows[4] = {8'h3c, 32'hffffffff, 32'h0};
    rows[5] = {REG_CKSUM, 32'hff, 32'h0};
    rows[6] = {8'h5c, 32'h2, 32'h2};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      wreg(rows[i][71:64], rows[i][63:32]);
      rchk(rows[i][71:64], rows[i][31:0]);
    end
    // Refused: intermediate word with no record open
    wreg(REG_REC_CMD, {30'h0, REC_MID});
    rchk(REG_STATUS, 32'h10);
    wreg(REG_STATUS, 32'h10);
    rchk(REG_STATUS, 32'h0);
    // Record with checksum wrapping past 21 bits
    wreg(REG_REC_DATA, 32'h0012_3456);
    wreg(REG_REC_CMD, {30'h0, REC_INIT});
    rchk(REG_CTRL, 32'h4);
    get_word(par(31'h0012_3456));
    wreg(REG_REC_DATA, 32'h5fff_ff00);
    wreg(REG_REC_CMD, {30'h0, REC_MID});
    get_word(par(31'h5fff_ff00));
    wreg(REG_REC_DATA, 32'h2000_0300);
    wreg(REG_REC_CMD, {30'h0, REC_MID});
    get_word(par(31'h2000_0300));
    wreg(REG_REC_DATA, 32'h0000_00a5);
    wreg(REG_REC_CMD, {30'h0, REC_CLOSE});
    get_word(par({FINAL_CODE, 21'h2, 8'ha5}));
    repeat (1300) @(posedge clk);
    rchk(REG_CKSUM, 32'h2);
    rchk(REG_CTRL, 32'h0);
    rchk(REG_STATUS, 32'h3);
    // Interrupt: masked, unmasked, cleared
    `CHK(irq_q, 1'b0)
    wreg(REG_MASK, 32'h2);
    repeat (3) @(posedge clk);
    #1 `CHK(irq_q, 1'b1)
    wreg(REG_STATUS, 32'h3);
    repeat (3) @(posedge clk);
    #1 `CHK(irq_q, 1'b0)
    // Second record: sum restarts, initial word excluded
    wreg(REG_REC_DATA, 32'h7fff_ffff);
    wreg(REG_REC_CMD, {30'h0, REC_INIT});
    get_word(par(31'h7fff_ffff));
    wreg(REG_REC_DATA, 32'h0000_1200);
    wreg(REG_REC_CMD, {30'h0, REC_MID});
    get_word(par(31'h0000_1200));
    wreg(REG_REC_DATA, 32'h0000_003c);
    wreg(REG_REC_CMD, {30'h0, REC_CLOSE});
    get_word(par({FINAL_CODE, 21'h12, 8'h3c}));
    repeat (1300) @(posedge clk);
    wreg(REG_STATUS, 32'h1f);
    // Slot pacing, normal then heavy load, unrefreshed repeats
    wreg({4'h4, SLOT_WORD, 2'h0}, 32'h0000_0077);
    wreg({4'h4, SLOT_MIN, 2'h0}, MN);
    wreg({4'h4, SLOT_MAX, 2'h0}, MX);
    wreg({4'h4, SLOT_FLAGS, 2'h0}, 32'h1);
    wreg(REG_CTRL, 32'h1);
    get_word(par(31'h77));
    t0 = rx_start;
    get_word(par(31'h77));
    dl = rx_start - t0;
    t0 = rx_start;
    `CHK(dl >= ((MN + MX) / 2 - 1) * TK && dl < MX * TK - 50, 1'b1)
    wreg(REG_CTRL, 32'h3);
    repeat (1300) @(posedge clk);
    // Overdue too: elapsed count ran past max before the first send
    rchk(REG_STATUS, 32'hd);
    // Held slot: unrefreshed resend must not count as stale
    wreg(REG_STATUS, 32'h1f);
    wreg({4'h4, SLOT_FLAGS, 2'h0}, 32'h3);
    get_word(par(31'h77));
    dl = rx_start - t0;
    `CHK(dl >= (MX - 1) * TK && dl <= (MX + 1) * TK + 20, 1'b1)
    rchk(REG_STATUS, 32'h0);
    `CHK(rx_bad, 1'b0)
    // Reset in mid-transfer
    repeat (300) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 `CHK({line_hi_q, line_lo_q, irq_q}, 3'h0)
    rchk(REG_STATUS, 32'h0);
    rchk(REG_CTRL, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire

// *** verification/swc_rx_model.sv ***
/*
  Receiving unit on the serial word line: decodes return-to-zero bits,
  bit 0 first, and flags even-parity words.
  Assumes the line is driven by swc_word_tx in the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module swc_rx_model import swc_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic hi,
  input wire logic lo,
  output logic [31:0] word_q,
  output logic got_q,
  output logic par_err_q,
  output logic bad_q,
  output logic [31:0] start_q
);
  logic [31:0] sh_q;
  logic [31:0] cyc_q;
  logic [5:0] cnt_q;
  logic act_q;
  logic [9:0] null_q;

  // ----------------------------------------
  // Bit decoder
  // ----------------------------------------
  // Detection only: a bad word is flagged, never retried or fixed
  always_ff @(posedge clk) begin
    got_q <= 1'b0;
    if (rst) begin
      {word_q, par_err_q, bad_q, start_q} <= '0;
      {sh_q, cyc_q, cnt_q, act_q, null_q} <= '0;
    end else begin
      cyc_q <= cyc_q + 32'h1;
      act_q <= hi | lo;
      // Null held mid-word means an open or grounded conductor
      if ((hi | lo) || cnt_q == 6'h0) begin
        null_q <= '0;
      end else if (null_q != '1) begin
        null_q <= null_q + 10'h1;
      end
      if ((hi & lo) || null_q == 10'(3 * HALF_BIT_CYC)) begin
        bad_q <= 1'b1;
      end else if ((hi | lo) & ~act_q & ~bad_q) begin
        if (cnt_q == 6'h0) begin
          start_q <= cyc_q;
        end
        if (cnt_q == 6'h1f) begin
          word_q <= {hi, sh_q[31:1]};
          par_err_q <= ~^{hi, sh_q[31:1]};
          got_q <= 1'b1;
          cnt_q <= 6'h0;
        end else begin
          sh_q <= {hi, sh_q[31:1]};
          cnt_q <= cnt_q + 6'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire
